// ===== src/lsa_map.svh
// offsets, field positions, reset values and bus codes of the light sensor target
`ifndef LSA_MAP_SVH
`define LSA_MAP_SVH
`define LSA_REG_RESULT   8'h00
`define LSA_REG_CONFIG   8'h01
`define LSA_REG_LOW      8'h02
`define LSA_REG_HIGH     8'h03
`define LSA_REG_MFG      8'h7e
`define LSA_REG_DEV      8'h7f
`define LSA_CFG_RESET    16'hc810
`define LSA_CFG_WMASK    16'hfe1f
`define LSA_LOW_RESET    16'h0000
`define LSA_HIGH_RESET   16'hffff
`define LSA_CFG_L        4
`define LSA_CFG_POL      3
`define LSA_MODE_SHUT    2'b00
`define LSA_EOC_CODE     2'b11
`define LSA_GC_ADDR      8'h00
`define LSA_GC_RESET     8'h06
`define LSA_ARA_BYTE     8'h19
`define LSA_HS_CODE      5'h01
`define LSA_SM_MAX_KHZ   100
`define LSA_FS_MAX_KHZ   400
`define LSA_HS_MAX_KHZ   2600
`define LSA_MIN_LINK_CYC 4
`endif

// ===== src/lsa_pkg.sv
// types of the light sensor target
package lsa_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_RX   = 3'b010,
      ST_ACK  = 3'b011,
      ST_TX   = 3'b100,
      ST_TXS  = 3'b101,
      ST_HACK = 3'b110
   } lsa_state_t;
   typedef enum logic [1:0] {
      EV_WRITE = 2'b00,
      EV_READ  = 2'b01,
      EV_GCRST = 2'b10,
      EV_ARA   = 2'b11
   } lsa_ev_kind_t;
   typedef struct packed {
      lsa_ev_kind_t kind;
      logic [7:0]   ptr;
      logic [15:0]  data;
   } lsa_ev_t;
   typedef struct packed {
      logic        done;
      logic        over;
      logic        under;
      logic        ovf;
      logic [15:0] result;
   } lsa_conv_t;
endpackage

// ===== src/lsa_target.sv
// light sensor bus target: pointer, registers, flags, alert response
`timescale 1ns/10ps
`include "lsa_map.svh"
// Function
// [RQ1] combined mode, over-limit: high flag set, low cleared, alert, done set
// [RQ2] combined mode, under-limit: low flag set, high cleared, alert, done set
// [RQ3] combined mode, plain conversion: alert and done set, flags kept
// [RQ4] combined mode: config read or non-shutdown write clears alert and done
// [RQ5] combined mode: shutdown config write changes no flag, alert or done
// [RQ6] combined mode: alert response touches no flag, alert or done
// [RQ7] accept standard, fast and high-speed bus rates; the link clock is checked against the fast-mode rate only
// [RQ8] first byte after write address loads the register pointer
// [RQ9] write: pointer then two data bytes, each acknowledged
// [RQ10] read uses last written pointer, kept across reads
// [RQ11] read sends high byte then low byte; host may stop anytime
// [RQ12] high-speed code is not acknowledged but switches filters
// [RQ13] stop returns filters to standard/fast operation
// [RQ14] general call then 06h: acknowledge and reset every register
// [RQ15] answer alert response only while latch bit is one
// [RQ16] host broadcasts alert response address while interrupt active
// [RQ17] alerting device acknowledges and sends its address, arbitrating
// [RQ18] lost arbitration: stop sending, keep alert active
// [RQ19] won arbitration: alert goes inactive
// [RQ20] over-limit flag is the last bit of returned address
// [RQ21] alert response clears neither limit flag
// [RQ22] low-limit top exponent bits 11 select end-of-conversion reporting
// [RQ23] latch bit zero selects transparent, one latched comparison
// [RQ24] strap pins set the two low address bits
module lsa_target #(
   parameter int          LINK_KHZ  = 6250,
   parameter logic [4:0]  ADDR_BASE = 5'h11,
   parameter logic [15:0] MFG_ID    = 16'h0a0a,  // arbitrary value
   parameter logic [15:0] DEV_ID    = 16'h0b0b   // arbitrary value
) (
   input  wire logic               i_clock,
   input  wire logic               i_srst,
   input  wire logic               i_link_clock,
   input  wire logic               i_scl,
   input  wire logic               i_sda,
   output logic                    o_sda,
   output logic                    o_sda_oe,
   input  wire logic [1:0]         i_addr_sel,
   input  wire lsa_pkg::lsa_conv_t i_conv,
   output logic                    o_int,
   output logic                    o_hs_mode,
   output logic [15:0]             o_config,
   output logic [15:0]             o_low_limit,
   output logic [15:0]             o_high_limit
);
   import lsa_pkg::*;

   // sampling needs several link cycles per bus clock period
   localparam int FS_CYC = LINK_KHZ / `LSA_FS_MAX_KHZ;
   if (FS_CYC < `LSA_MIN_LINK_CYC) begin : g_chk // RQ7
      $error("link clock too slow for fast mode");
   end

   // core side state
   logic [15:0] cfg_reg, low_reg, high_reg, result_reg, rd_word_reg;
   logic        ovf_reg, crf_reg, fh_reg, fl_reg, alert_reg, rd_tgl_reg;
   logic [2:0]  et_s_reg;
   logic        ev_new, ev_wr, ev_rd, ev_gc, ev_ara, wr_cfg, rd_cfg;
   logic        eoc, latched, combined, shut_wr, clr_crf, clr_flg, clr_alert;
   logic        done, over, under, set_alert, drop_alert;
   logic        fh_next, fl_next, crf_next, alert_next;
   logic [15:0] cfg_view, rd_sel;

   // link side state
   logic [1:0]  lrst_s_reg;
   logic [3:0]  pin_s1_reg, pin_s2_reg;
   logic [1:0]  bus_q_reg;
   logic [2:0]  st_s1_reg, st_s2_reg;
   logic [2:0]  rt_s_reg;
   lsa_state_t  st_reg, nxt_reg;
   logic [2:0]  cnt_reg;
   logic [7:0]  sh_reg, ptr_reg, hi_reg;
   logic [1:0]  idx_reg;
   logic        ph_reg, gc_reg, ara_reg, sda_oe_reg, hs_reg, ev_tgl_reg;
   logic        strap_ok_reg;
   logic [6:0]  own_reg;
   logic [15:0] rd_buf_reg;
   lsa_ev_t     ev_reg;
   logic        lrst, scl, sda, scl_rise, scl_fall, start_det, stop_det;
   logic        last_bit, is_own, is_gc, is_ara, is_hs, addr_ack, rx_ack;
   logic        latch_s, alert_s, fh_s, rt_new, ara_lost;
   logic [7:0]  byte_in, ara_byte, tx_load;

   // link domain synchronisers; stage two is read, and a third stage of scl, sda and the read toggle feeds edge detection
   always_ff @(posedge i_link_clock) begin
      lrst_s_reg <= {lrst_s_reg[0], i_srst};
      pin_s1_reg <= {i_addr_sel, i_scl, i_sda};
      pin_s2_reg <= pin_s1_reg;
      bus_q_reg  <= pin_s2_reg[1:0];
      st_s1_reg  <= {cfg_reg[`LSA_CFG_L], alert_reg, fh_reg};
      st_s2_reg  <= st_s1_reg;
      rt_s_reg   <= {rt_s_reg[1:0], rd_tgl_reg};
   end

   assign lrst      = lrst_s_reg[1];
   assign scl       = pin_s2_reg[1];
   assign sda       = pin_s2_reg[0];
   assign latch_s   = st_s2_reg[2];
   assign alert_s   = st_s2_reg[1];
   assign fh_s      = st_s2_reg[0];
   assign rt_new    = rt_s_reg[2] ^ rt_s_reg[1];
   assign scl_rise  = scl & ~bus_q_reg[1];
   assign scl_fall  = ~scl & bus_q_reg[1];
   assign start_det = scl & bus_q_reg[1] & bus_q_reg[0] & ~sda;
   assign stop_det  = scl & bus_q_reg[1] & ~bus_q_reg[0] & sda;
   assign byte_in   = {sh_reg[6:0], sda};
   assign last_bit  = scl_rise & (cnt_reg == 3'd7);
   assign is_own    = byte_in[7:1] == own_reg;
   assign is_gc     = byte_in == `LSA_GC_ADDR;
   assign is_ara    = (byte_in == `LSA_ARA_BYTE) & latch_s & alert_s; // RQ15
   assign is_hs     = byte_in[7:3] == `LSA_HS_CODE;
   assign addr_ack  = is_own | is_gc | is_ara;
   assign rx_ack    = gc_reg ? (byte_in == `LSA_GC_RESET) & (idx_reg == 2'd0)
                             : (idx_reg != 2'd3);
   assign ara_byte  = {own_reg, fh_s}; // RQ20
   assign tx_load   = ara_reg ? ara_byte : rd_buf_reg[15:8];
   // released line read low means a lower address is sending
   assign ara_lost  = (st_reg == ST_TX) & ara_reg & scl_rise & ~sda_oe_reg & ~sda;

   // strap and read word capture
   always_ff @(posedge i_link_clock) begin
      if (lrst) begin
         own_reg      <= 7'h00;
         strap_ok_reg <= 1'b0;
         rd_buf_reg   <= 16'h0000;
      end else begin
         if (!strap_ok_reg) begin
            own_reg      <= {ADDR_BASE, pin_s2_reg[3:2]}; // RQ24
            strap_ok_reg <= 1'b1;
         end
         if (rt_new) begin
            rd_buf_reg <= rd_word_reg; // RQ10
         end
      end
   end

   // bus protocol engine
   always_ff @(posedge i_link_clock) begin
      if (lrst) begin
         st_reg     <= ST_IDLE;
         nxt_reg    <= ST_IDLE;
         cnt_reg    <= 3'd0;
         sh_reg     <= 8'h00;
         ptr_reg    <= 8'h00;
         hi_reg     <= 8'h00;
         idx_reg    <= 2'd0;
         ph_reg     <= 1'b0;
         gc_reg     <= 1'b0;
         ara_reg    <= 1'b0;
         sda_oe_reg <= 1'b0;
         hs_reg     <= 1'b0;
         ev_tgl_reg <= 1'b0;
         ev_reg     <= '{EV_WRITE, 8'h00, 16'h0000};
      end else if (stop_det) begin
         st_reg     <= ST_IDLE;
         sda_oe_reg <= 1'b0;
         hs_reg     <= 1'b0; // RQ13
      end else if (start_det) begin
         // repeated start keeps high-speed filters
         st_reg     <= ST_ADDR;
         cnt_reg    <= 3'd0;
         idx_reg    <= 2'd0;
         sda_oe_reg <= 1'b0;
         gc_reg     <= 1'b0;
         ara_reg    <= 1'b0;
      end else begin
         case (st_reg)
            ST_ADDR: begin
               if (scl_rise) begin
                  sh_reg  <= byte_in;
                  cnt_reg <= cnt_reg + 3'd1;
               end
               if (last_bit) begin
                  st_reg  <= addr_ack ? ST_ACK : ST_IDLE; // RQ12
                  ph_reg  <= 1'b0;
                  gc_reg  <= is_gc;
                  ara_reg <= is_ara & ~is_own; // RQ17
                  hs_reg  <= hs_reg | is_hs; // RQ12
                  nxt_reg <= byte_in[0] ? ST_TX : ST_RX;
                  if (is_own & byte_in[0]) begin
                     ev_reg     <= '{EV_READ, ptr_reg, 16'h0000}; // RQ10
                     ev_tgl_reg <= ~ev_tgl_reg;
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  sh_reg  <= byte_in;
                  cnt_reg <= cnt_reg + 3'd1;
               end
               if (last_bit) begin
                  st_reg  <= rx_ack ? ST_ACK : ST_IDLE; // RQ9
                  ph_reg  <= 1'b0;
                  nxt_reg <= ST_RX;
                  idx_reg <= (idx_reg == 2'd3) ? idx_reg : idx_reg + 2'd1;
                  if (rx_ack & gc_reg) begin
                     ptr_reg    <= 8'h00; // RQ14
                     ev_reg     <= '{EV_GCRST, 8'h00, 16'h0000};
                     ev_tgl_reg <= ~ev_tgl_reg;
                  end else if (rx_ack & (idx_reg == 2'd0)) begin
                     ptr_reg <= byte_in; // RQ8
                  end else if (rx_ack & (idx_reg == 2'd1)) begin
                     hi_reg <= byte_in; // RQ9
                  end else if (rx_ack & (idx_reg == 2'd2)) begin
                     ev_reg     <= '{EV_WRITE, ptr_reg, {hi_reg, byte_in}}; // RQ9
                     ev_tgl_reg <= ~ev_tgl_reg;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall & !ph_reg) begin
                  sda_oe_reg <= 1'b1;
                  ph_reg     <= 1'b1;
               end else if (scl_fall) begin
                  ph_reg  <= 1'b0;
                  cnt_reg <= 3'd0;
                  if (nxt_reg == ST_TX) begin
                     sh_reg     <= tx_load; // RQ11
                     sda_oe_reg <= ~tx_load[7];
                     st_reg     <= ST_TX;
                  end else begin
                     sda_oe_reg <= 1'b0;
                     st_reg     <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (ara_lost) begin
                  st_reg <= ST_IDLE; // RQ18
               end else if (scl_rise) begin
                  cnt_reg <= cnt_reg + 3'd1;
                  if (cnt_reg == 3'd7) begin
                     st_reg <= ST_HACK;
                     if (ara_reg) begin
                        ev_reg     <= '{EV_ARA, 8'h00, 16'h0000}; // RQ19
                        ev_tgl_reg <= ~ev_tgl_reg;
                     end
                  end
               end else if (scl_fall) begin
                  sh_reg     <= {sh_reg[6:0], 1'b0};
                  sda_oe_reg <= ~sh_reg[6];
               end
            end
            ST_HACK: begin
               if (scl_fall) begin
                  sda_oe_reg <= 1'b0;
               end else if (scl_rise) begin
                  // host nack or second byte done ends the read
                  if (!sda & !ara_reg & (idx_reg == 2'd0)) begin
                     idx_reg <= 2'd1; // RQ11
                     sh_reg  <= rd_buf_reg[7:0];
                     cnt_reg <= 3'd0;
                     st_reg  <= ST_TXS;
                  end else begin
                     st_reg <= ST_IDLE;
                  end
               end
            end
            ST_TXS: begin
               if (scl_fall) begin
                  sda_oe_reg <= ~sh_reg[7];
                  st_reg     <= ST_TX;
               end
            end
            ST_IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            default: begin
               st_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // core side: event toggle crossing, payload stable by then
   always_ff @(posedge i_clock) begin
      et_s_reg <= {et_s_reg[1:0], ev_tgl_reg};
   end

   assign ev_new   = et_s_reg[2] ^ et_s_reg[1];
   assign ev_wr    = ev_new & (ev_reg.kind == EV_WRITE);
   assign ev_rd    = ev_new & (ev_reg.kind == EV_READ);
   assign ev_gc    = ev_new & (ev_reg.kind == EV_GCRST);
   assign ev_ara   = ev_new & (ev_reg.kind == EV_ARA);
   assign wr_cfg   = ev_wr & (ev_reg.ptr == `LSA_REG_CONFIG);
   assign rd_cfg   = ev_rd & (ev_reg.ptr == `LSA_REG_CONFIG);
   assign eoc      = low_reg[15:14] == `LSA_EOC_CODE; // RQ22
   assign latched  = cfg_reg[`LSA_CFG_L]; // RQ23
   assign combined = eoc & ~latched;
   assign shut_wr  = wr_cfg & (ev_reg.data[10:9] == `LSA_MODE_SHUT); // RQ5
   assign clr_crf  = rd_cfg | (wr_cfg & ~shut_wr); // RQ4
   assign clr_flg  = latched & rd_cfg; // RQ21
   // transparent modes ignore the alert response entirely
   assign clr_alert = combined ? clr_crf : latched & (rd_cfg | ev_ara); // RQ4 RQ6
   assign done     = i_conv.done;
   assign over     = done & i_conv.over;
   assign under    = done & i_conv.under & ~i_conv.over;
   // set terms come last so an event beats a clear in the same cycle
   assign fh_next  = (fh_reg & ~clr_flg & ~(under & ~latched)) | over; // RQ1
   assign fl_next  = (fl_reg & ~clr_flg & ~(over & ~latched)) | under; // RQ2
   assign crf_next = (crf_reg & ~clr_crf) | done; // RQ3
   assign set_alert  = done & (eoc | over | (latched & under)); // RQ1 RQ2 RQ3
   assign drop_alert = under & ~eoc & ~latched;
   assign alert_next = (alert_reg & ~clr_alert & ~drop_alert) | set_alert;
   assign cfg_view = {cfg_reg[15:9], ovf_reg, crf_reg, fh_reg, fl_reg, cfg_reg[4:0]};
   assign rd_sel   = (ev_reg.ptr == `LSA_REG_RESULT) ? result_reg :
                     (ev_reg.ptr == `LSA_REG_CONFIG) ? cfg_view :
                     (ev_reg.ptr == `LSA_REG_LOW)    ? low_reg :
                     (ev_reg.ptr == `LSA_REG_HIGH)   ? high_reg :
                     (ev_reg.ptr == `LSA_REG_MFG)    ? MFG_ID :
                     (ev_reg.ptr == `LSA_REG_DEV)    ? DEV_ID : 16'h0000;

   always_ff @(posedge i_clock) begin
      if (i_srst | ev_gc) begin // RQ14
         cfg_reg    <= `LSA_CFG_RESET;
         low_reg    <= `LSA_LOW_RESET;
         high_reg   <= `LSA_HIGH_RESET;
         result_reg <= 16'h0000;
         ovf_reg    <= 1'b0;
         crf_reg    <= 1'b0;
         fh_reg     <= 1'b0;
         fl_reg     <= 1'b0;
         alert_reg  <= 1'b0;
      end else begin
         fh_reg    <= fh_next;
         fl_reg    <= fl_next;
         crf_reg   <= crf_next;
         alert_reg <= alert_next;
         if (done) begin
            result_reg <= i_conv.result;
            ovf_reg    <= i_conv.ovf;
         end
         if (wr_cfg) begin
            cfg_reg <= ev_reg.data & `LSA_CFG_WMASK;
         end
         if (ev_wr & (ev_reg.ptr == `LSA_REG_LOW)) begin
            low_reg <= ev_reg.data;
         end
         if (ev_wr & (ev_reg.ptr == `LSA_REG_HIGH)) begin
            high_reg <= ev_reg.data;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         rd_word_reg <= 16'h0000;
         rd_tgl_reg  <= 1'b0;
      end else if (ev_rd) begin
         rd_word_reg <= rd_sel; // RQ10
         rd_tgl_reg  <= ~rd_tgl_reg;
      end
   end

   assign o_sda        = 1'b0;
   assign o_sda_oe     = sda_oe_reg;
   assign o_hs_mode    = hs_reg;
   assign o_int        = cfg_reg[`LSA_CFG_POL] ? alert_reg : ~alert_reg;
   assign o_config     = cfg_view;
   assign o_low_limit  = low_reg;
   assign o_high_limit = high_reg;

   property p_over;
      @(posedge i_clock) disable iff (i_srst)
      (combined & over & ~ev_gc) |=> fh_reg & ~fl_reg & crf_reg & alert_reg;
   endproperty
   a_over: assert property (p_over) // RQ1
      else $error("over-limit event not reported");

   property p_under;
      @(posedge i_clock) disable iff (i_srst)
      (combined & under & ~ev_gc) |=> ~fh_reg & fl_reg & crf_reg & alert_reg;
   endproperty
   a_under: assert property (p_under) // RQ2
      else $error("under-limit event not reported");

   property p_cfg_rd;
      @(posedge i_clock) disable iff (i_srst)
      (combined & rd_cfg & ~done) |=> ~crf_reg & ~alert_reg;
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) // RQ4
      else $error("config read left done or alert set");

   property p_shut;
      @(posedge i_clock) disable iff (i_srst)
      (combined & shut_wr & ~done) |=> $stable(fh_reg) && $stable(fl_reg)
         && $stable(crf_reg) && $stable(alert_reg);
   endproperty
   a_shut: assert property (p_shut) // RQ5
      else $error("shutdown write changed flags");

   property p_gc;
      @(posedge i_clock) disable iff (i_srst)
      ev_gc |=> (cfg_reg == `LSA_CFG_RESET) && (low_reg == `LSA_LOW_RESET)
         && (high_reg == `LSA_HIGH_RESET) && !alert_reg;
   endproperty
   a_gc: assert property (p_gc) // RQ14
      else $error("general call did not reset registers");

   property p_ara_win;
      @(posedge i_clock) disable iff (i_srst)
      (latched & ev_ara & ~done) |=> !alert_reg && $stable(fh_reg) && $stable(fl_reg);
   endproperty
   a_ara_win: assert property (p_ara_win) // RQ19
      else $error("alert response win mishandled");

   property p_hs;
      @(posedge i_link_clock) disable iff (lrst)
      (st_reg == ST_ADDR & last_bit & is_hs) |=> (hs_reg && !o_sda_oe) [*2];
   endproperty
   a_hs: assert property (p_hs) // RQ12
      else $error("high-speed code acknowledged");

   property p_stop;
      @(posedge i_link_clock) disable iff (lrst)
      stop_det |=> !hs_reg && (st_reg == ST_IDLE);
   endproperty
   a_stop: assert property (p_stop) // RQ13
      else $error("stop did not leave high-speed mode");

   property p_ara_gate;
      @(posedge i_link_clock) disable iff (lrst)
      (st_reg == ST_ADDR & last_bit & (byte_in == `LSA_ARA_BYTE) & ~latch_s & ~is_own)
         |=> (st_reg == ST_IDLE);
   endproperty
   a_ara_gate: assert property (p_ara_gate) // RQ15
      else $error("alert response answered in transparent mode");

   property p_lost;
      @(posedge i_link_clock) disable iff (lrst)
      ara_lost |=> (st_reg == ST_IDLE) && $stable(ev_tgl_reg);
   endproperty
   a_lost: assert property (p_lost) // RQ18
      else $error("lost arbitration not abandoned");

   property p_ptr;
      @(posedge i_link_clock) disable iff (lrst)
      (st_reg == ST_RX & last_bit & ~gc_reg & (idx_reg == 2'd0)) |=> ptr_reg == $past(byte_in);
   endproperty
   a_ptr: assert property (p_ptr) // RQ8
      else $error("pointer byte not loaded");

   c_over: cover property (@(posedge i_clock) disable iff (i_srst) combined & over);
   c_ara: cover property (@(posedge i_clock) disable iff (i_srst) ev_ara);
   c_gc: cover property (@(posedge i_clock) disable iff (i_srst) ev_gc);
   c_hs: cover property (@(posedge i_link_clock) disable iff (lrst) $rose(hs_reg));
endmodule

// ===== tb/lsa_host.sv
// bus host model: start, stop and byte transfers on an open-drain pair
`timescale 1ns/10ps
module lsa_host #(
   parameter int Q = 260
) (
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_pull
);
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
   end
   // start or repeated start; scl stands still outside frames
   task automatic start();
      o_sda_pull = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda_pull = 1'b1;
      #Q o_scl = 1'b0;
      #Q;
   endtask
   task automatic stop();
      o_sda_pull = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda_pull = 1'b0;
      #(2*Q);
   endtask
   // msb first, then ninth bit; a 1 releases the line to the pull-up
   // low phase of 2*Q outlasts the target's three-cycle release latency
   task automatic xfer(input logic [7:0] tx, input logic nine,
                       output logic [7:0] rx, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         o_sda_pull = (i > 0) ? !tx[i-1] : !nine;
         #(2*Q) o_scl = 1'b1;
         #Q;
         if (i > 0) rx[i-1] = i_sda;
         else ack = !i_sda;
         #Q o_scl = 1'b0;
      end
   endtask
endmodule

// ===== tb/tb.sv
// self-checking bench of the light sensor target
`timescale 1ns/10ps
`include "lsa_map.svh"
module tb;
   import lsa_pkg::*;
   localparam logic [4:0] BASE = 5'h11;
   logic              i_clock, i_srst, i_link_clock, scl, pull, ack;
   logic [1:0]        sel;
   lsa_conv_t         conv;
   logic              o_sda, o_sda_oe, o_int, o_hs_mode, fh, fl, conv_done_flag, alrt;
   logic [15:0]       o_config, o_low_limit, o_high_limit, wcfg, wlow, w;
   logic [7:0]        rx;
   logic [6:0]        me;
   int                miscompares = 0;
   int                num_checks = 0;
   wire logic         sda = !(pull || (o_sda_oe && !o_sda));
   lsa_target #(.ADDR_BASE(BASE)) uut (.i_clock(i_clock), .i_srst(i_srst),
      .i_link_clock(i_link_clock), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
      .o_sda_oe(o_sda_oe), .i_addr_sel(sel), .i_conv(conv), .o_int(o_int),
      .o_hs_mode(o_hs_mode), .o_config(o_config), .o_low_limit(o_low_limit),
      .o_high_limit(o_high_limit));
   lsa_host host (.i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   // link clock unrelated in phase to the core clock
   initial begin
      i_link_clock = 1'b0;
      #37;
      forever #80 i_link_clock = ~i_link_clock;
   end
   initial begin
      repeat (95000) @(posedge i_clock);
      miscompares++;
      final_report();
   end
   task automatic final_report();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] cv();
      return (wcfg & `LSA_CFG_WMASK) | {8'h00, conv_done_flag, fh, fl, 5'h00};
   endfunction
   task automatic dflt();
      wcfg = `LSA_CFG_RESET;
      wlow = `LSA_LOW_RESET;
      {fh, fl, conv_done_flag, alrt} = 4'h0;
   endtask
   // polarity stays 0 here, so the pin is the inverse of alert
   task automatic st();
      chk(o_config, cv());
      chk(16'(o_int), 16'(!alrt));
      chk(o_low_limit, wlow);
      chk(o_high_limit, `LSA_HIGH_RESET);
   endtask
   task automatic cnv(input int k);  // k: 0 plain, 1 over, 2 under
      @(posedge i_clock);
      #1 conv = '{1'b1, k == 1, k == 2, 1'b0, 16'($urandom)};
      @(posedge i_clock);
      #1 conv.done = 1'b0;
      if (k == 1) fh = 1'b1;
      if (k == 2) fl = 1'b1;
      if (k == 1 && !wcfg[`LSA_CFG_L]) fl = 1'b0;
      if (k == 2 && !wcfg[`LSA_CFG_L]) fh = 1'b0;
      alrt = 1'b1;
      conv_done_flag = 1'b1;
      repeat (3) @(posedge i_clock);
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
      logic [31:0] b;
      b = {me, 1'b0, p, d};
      host.start();
      for (int i = 0; i < n; i++) begin
         host.xfer(b[31-8*i -: 8], 1'b1, rx, ack);
         chk(16'(ack), 16'h1);
      end
      host.stop();
   endtask
   // the host refuses the last byte, ending the read early when n is 1
   task automatic rd(input int n, output logic [15:0] v);
      host.start();
      host.xfer({me, 1'b1}, 1'b1, rx, ack);
      chk(16'(ack), 16'h1);
      v = 16'h0;
      for (int i = 0; i < n; i++) begin
         host.xfer(8'hff, i == n - 1, rx, ack);
         v = {v[7:0], rx};
      end
      host.stop();
   endtask
   task automatic ara(input logic [7:0] cmp, input logic want, output logic [7:0] got);
      host.start();
      host.xfer(`LSA_ARA_BYTE, 1'b1, rx, ack);
      chk(16'(ack), 16'(want));
      if (ack) host.xfer(cmp, 1'b1, got, ack);
      host.stop();
   endtask
   initial begin
      void'($urandom(64497));
      sel = 2'($urandom);
      me = {BASE, sel};
      conv = '0;
      i_srst = 1'b1;
      dflt();
      repeat (12) @(posedge i_link_clock);
      @(posedge i_clock);
      #1 i_srst = 1'b0;
      repeat (6) @(posedge i_link_clock);
      chk(16'(o_hs_mode), 16'h0);
      st();
      wlow = 16'hc000 | (16'($urandom) & 16'h3fff);
      wr(`LSA_REG_LOW, wlow, 4);
      wcfg = 16'hca00;
      wr(`LSA_REG_CONFIG, wcfg, 4);
      st();
      repeat (8) begin
         cnv($urandom_range(2));
         st();
      end
      rd(1, w);
      chk(w, 16'(cv() >> 8));
      conv_done_flag = 1'b0;
      alrt = 1'b0;
      st();
      cnv(1);
      wcfg = 16'hc800;
      wr(`LSA_REG_CONFIG, wcfg, 4);
      st();
      ara(8'hff, 1'b0, rx);
      st();
      wcfg = 16'hca00;
      wr(`LSA_REG_CONFIG, wcfg, 4);
      conv_done_flag = 1'b0;
      alrt = 1'b0;
      st();
      wr(`LSA_REG_LOW, 16'h0, 2);
      rd(2, w);
      chk(w, wlow);
      host.start();
      host.xfer({`LSA_HS_CODE, 3'($urandom)}, 1'b1, rx, ack);
      chk(16'(ack), 16'h0);
      chk(16'(o_hs_mode), 16'h1);
      host.start();
      host.stop();
      chk(16'(o_hs_mode), 16'h0);
      wcfg = 16'hca10;
      wr(`LSA_REG_CONFIG, wcfg, 4);
      cnv(1);
      st();
      // a lower competing address pulls every bit low, so the design loses
      ara(8'h00, 1'b1, rx);
      chk(16'(rx), 16'h0);
      st();
      ara(8'hff, 1'b1, rx);
      chk(16'(rx), {8'h00, me, fh});
      alrt = 1'b0;
      st();
      host.start();
      host.xfer(`LSA_GC_ADDR, 1'b1, rx, ack);
      chk(16'(ack), 16'h1);
      host.xfer(`LSA_GC_RESET, 1'b1, rx, ack);
      chk(16'(ack), 16'h1);
      host.stop();
      dflt();
      st();
      final_report();
   end
endmodule
